// ===== shr_homing.v
// Purpose: Safety homing in reference-switch mode with Wishbone registers
// Assumes: Encoder position is sampled once per clock (one safety cycle)
// Notes:   Fail safe is left only through rst_i, standing in for power cycle
//
// Contract
// - Unwired switch input latches permanent fail safe
// - Request rise selects edge by polarity, direction
// - Overspeed switch transitions are discarded
// - Speed limit covers switch and pulse, default 0
// - Positive edge: low to high moving positive
// - Trigger direction selects evaluated travel direction
// - Timeout gives acknowledgeable fault, no torque
// - Configuration defaults all zero, direct, positive
// - Pulse blocked over percent-of-revolution distance
// - No pulse: home loaded at switch edge
// - Pulse used: reference taken at later pulse
// - Ignore pulses until blocking distance travelled
// - Reversal during pulse search discards edge
// - Overspeed during pulse search gives fault
`default_nettype none
`include "shr_defs.vh"
module shr_homing #(
  parameter REV_UNITS = 32'd65536
) (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Axis and switch
  input  wire        homing_request_in_i,
  input  wire        ref_switch_in_i,
  input  wire        ref_switch_wired_i,
  input  wire        ref_pulse_i,
  input  wire [31:0] enc_pos_i,
  // Results
  output reg         no_func_error_out_o,
  output reg         torque_enable_o,
  output reg         fail_safe_o,
  output reg         homed_o,
  output reg  [31:0] axis_pos_o,
  output reg         irq_o
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SWSRC = 3'h1;
  localparam ST_PLSRC = 3'h2;
  localparam ST_FAULT = 3'h3;
  localparam ST_FAIL  = 3'h4;

  // Configuration and status registers
  reg [4:0]          ctrl_ff;
  reg [31:0]         home_ff;
  reg [31:0]         maxspd_ff;
  reg [31:0]         montime_ff;
  reg [6:0]          block_ff;
  reg [`SHR_EV_W-1:0] int_st_ff;
  reg [`SHR_EV_W-1:0] int_en_ff;
  reg [31:0]         ref_ofs_ff;
  reg [2:0]          state_ff;
  reg                homed_ff;
  reg                dir_neg_ff;
  reg [31:0]         prev_pos_ff;
  reg [39:0]         timer_ff;
  reg [31:0]         travel_ff;

  // Next values
  reg [2:0]          nxt_state;
  reg                nxt_homed;
  reg [31:0]         nxt_ref_ofs;
  reg [39:0]         nxt_timer;
  reg [31:0]         nxt_travel;
  reg                nxt_dir_neg;
  reg [`SHR_EV_W-1:0] ev;

  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;
  assign lvl = {ref_pulse_i, ref_switch_in_i, homing_request_in_i};

  shr_edge #(.W(3)) u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .lvl_i  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  wire req_rise   = rise[0];
  wire pulse_rise = rise[2];

  // Speed from position change per cycle, scaled to units per second
  wire [31:0] delta     = enc_pos_i - prev_pos_ff;
  wire [31:0] abs_delta = delta[31] ? (32'h0 - delta) : delta;
  wire [63:0] speed_ups = {32'h0, abs_delta} * {32'h0, `SHR_CLK_HZ};
  wire        overspeed = speed_ups > {32'h0, maxspd_ff};
  wire        moving    = |delta;
  wire        mv_neg    = delta[31];

  wire        cfg_edge_neg = ctrl_ff[`SHR_CTRL_EDGE];
  wire        cfg_dir_neg  = ctrl_ff[`SHR_CTRL_DIR];
  wire        cfg_pulse    = ctrl_ff[`SHR_CTRL_PULSE];
  wire [1:0]  cfg_mode     = ctrl_ff[`SHR_CTRL_MODE_HI:`SHR_CTRL_MODE_LO];

  // Positive edge is low to high seen while travelling positive;
  // travelling negative the same physical edge shows as high to low.
  wire in_dir   = moving & (mv_neg == cfg_dir_neg);
  wire want_up  = (cfg_edge_neg == cfg_dir_neg);
  wire sw_trans = want_up ? rise[1] : fall[1];
  wire sw_hit   = in_dir & sw_trans;

  // Timeout of zero disables supervision, otherwise a search faults after montime_ff microseconds
  wire [39:0] mon_cycles = {8'h0, montime_ff} * {8'h0, `SHR_CYC_PER_US};
  wire        timed_out  = (montime_ff != 32'h0) && (timer_ff >= mon_cycles);

  // Blocking distance compared without division
  wire [47:0] travel_x100 = {16'h0, travel_ff} * 48'd100;
  wire [47:0] block_units = {41'h0, block_ff} * {16'h0, REV_UNITS};
  wire        blocked     = travel_x100 < block_units;

  wire [31:0] ofs_now = home_ff - enc_pos_i;

  // Bus decode
  wire        bus_req = cyc_i & stb_i & ~ack_o;
  wire        wr      = bus_req & we_i;
  wire        wr_cmd  = wr & (adr_i == `SHR_OFS_CMD) & sel_i[0];
  wire        fault_ack = wr_cmd & dat_i[`SHR_CMD_ACK];
  wire        wr_clr  = wr & (adr_i == `SHR_OFS_INTCLR) & sel_i[0];

  always @* begin
    nxt_state   = state_ff;
    nxt_homed   = homed_ff;
    nxt_ref_ofs = ref_ofs_ff;
    nxt_timer   = timer_ff;
    nxt_travel  = travel_ff;
    nxt_dir_neg = dir_neg_ff;
    ev          = {`SHR_EV_W{1'b0}};
    case (state_ff)
      ST_IDLE: begin
        if (req_rise) begin
          nxt_homed = 1'b0;
          nxt_timer = 40'h0;
          if (cfg_mode == `SHR_MODE_DIRECT) begin
            nxt_ref_ofs = ofs_now;
            nxt_homed   = 1'b1;
            ev[`SHR_EV_HOMED] = 1'b1;
          end else begin
            nxt_state = ST_SWSRC;
          end
        end
      end
      ST_SWSRC: begin
        nxt_timer = timer_ff + 40'h1;
        if (timed_out) begin
          nxt_state = ST_FAULT;
          ev[`SHR_EV_FAULT] = 1'b1;
        end else if (sw_hit && overspeed) begin
          ev[`SHR_EV_DISCARD] = 1'b1;
        end else if (sw_hit) begin
          if (cfg_pulse) begin
            nxt_state   = ST_PLSRC;
            nxt_travel  = 32'h0;
            nxt_dir_neg = mv_neg;
          end else begin
            nxt_ref_ofs = ofs_now;
            nxt_homed   = 1'b1;
            nxt_state   = ST_IDLE;
            ev[`SHR_EV_HOMED] = 1'b1;
          end
        end
      end
      ST_PLSRC: begin
        nxt_timer  = timer_ff + 40'h1;
        nxt_travel = travel_ff + abs_delta;
        if (timed_out) begin
          nxt_state = ST_FAULT;
          ev[`SHR_EV_FAULT] = 1'b1;
        end else if (overspeed) begin
          nxt_state = ST_FAULT;
          ev[`SHR_EV_FAULT] = 1'b1;
        end else if (moving && (mv_neg != dir_neg_ff)) begin
          nxt_state = ST_SWSRC;
          ev[`SHR_EV_DISCARD] = 1'b1;
        end else if (pulse_rise && !blocked) begin
          nxt_ref_ofs = ofs_now;
          nxt_homed   = 1'b1;
          nxt_state   = ST_IDLE;
          ev[`SHR_EV_HOMED] = 1'b1;
        end
      end
      ST_FAULT: begin
        nxt_homed = 1'b0;
        if (fault_ack) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FAIL: begin
        nxt_homed = 1'b0;
      end
      default: begin
        nxt_state = ST_FAIL;
        nxt_homed = 1'b0;
      end
    endcase
    // An unwired switch overrides everything and never recovers
    if (!ref_switch_wired_i && state_ff != ST_FAIL) begin
      nxt_state = ST_FAIL;
      nxt_homed = 1'b0;
      ev[`SHR_EV_FAILSAFE] = 1'b1;
    end
    if (nxt_state == ST_FAULT && state_ff != ST_FAULT) begin
      nxt_homed = 1'b0;
    end
  end

  // Homing state and outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff            <= ST_IDLE;
      homed_ff            <= 1'b0;
      ref_ofs_ff          <= 32'h0;
      timer_ff            <= 40'h0;
      travel_ff           <= 32'h0;
      dir_neg_ff          <= 1'b0;
      prev_pos_ff         <= 32'h0;
      no_func_error_out_o <= 1'b0;
      torque_enable_o     <= 1'b0;
      fail_safe_o         <= 1'b0;
      homed_o             <= 1'b0;
      axis_pos_o          <= 32'h0;
    end else if (ce_i) begin
      state_ff            <= nxt_state;
      homed_ff            <= nxt_homed;
      ref_ofs_ff          <= nxt_ref_ofs;
      timer_ff            <= nxt_timer;
      travel_ff           <= nxt_travel;
      dir_neg_ff          <= nxt_dir_neg;
      prev_pos_ff         <= enc_pos_i;
      no_func_error_out_o <= (nxt_state != ST_FAULT) && (nxt_state != ST_FAIL);
      torque_enable_o     <= (nxt_state != ST_FAULT) && (nxt_state != ST_FAIL);
      fail_safe_o         <= (nxt_state == ST_FAIL);
      homed_o             <= nxt_homed;
      axis_pos_o          <= enc_pos_i + nxt_ref_ofs;
    end
  end

  // Configuration writes, byte lanes honoured
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff    <= `SHR_RST_CTRL;
      home_ff    <= `SHR_RST_HOME;
      maxspd_ff  <= `SHR_RST_MAXSPD;
      montime_ff <= `SHR_RST_MONTIME;
      block_ff   <= `SHR_RST_BLOCK;
      int_en_ff  <= {`SHR_EV_W{1'b0}};
    end else if (ce_i && wr) begin
      case (adr_i)
        `SHR_OFS_CTRL: begin
          if (sel_i[0]) begin
            ctrl_ff <= dat_i[4:0];
          end
        end
        `SHR_OFS_HOME: begin
          home_ff <= lane_merge(home_ff, dat_i, sel_i);
        end
        `SHR_OFS_MAXSPD: begin
          maxspd_ff <= lane_merge(maxspd_ff, dat_i, sel_i);
        end
        `SHR_OFS_MONTIME: begin
          montime_ff <= lane_merge(montime_ff, dat_i, sel_i);
        end
        `SHR_OFS_BLOCK: begin
          if (sel_i[0]) begin
            block_ff <= dat_i[6:0];
          end
        end
        `SHR_OFS_INTEN: begin
          if (sel_i[0]) begin
            int_en_ff <= dat_i[`SHR_EV_W-1:0];
          end
        end
        default: begin
          ctrl_ff <= ctrl_ff;
        end
      endcase
    end
  end

  // Sticky events; a new event in the clearing cycle survives
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_st_ff <= {`SHR_EV_W{1'b0}};
      irq_o     <= 1'b0;
    end else if (ce_i) begin
      if (wr_clr) begin
        int_st_ff <= (int_st_ff & ~dat_i[`SHR_EV_W-1:0]) | ev;
      end else begin
        int_st_ff <= int_st_ff | ev;
      end
      irq_o <= |(int_st_ff & int_en_ff);
    end
  end

  // Bus answer: one wait state, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= bus_req;
      dat_o <= 32'h0;
      if (bus_req && !we_i) begin
        case (adr_i)
          `SHR_OFS_CTRL:    dat_o <= {27'h0, ctrl_ff};
          `SHR_OFS_HOME:    dat_o <= home_ff;
          `SHR_OFS_MAXSPD:  dat_o <= maxspd_ff;
          `SHR_OFS_MONTIME: dat_o <= montime_ff;
          `SHR_OFS_BLOCK:   dat_o <= {25'h0, block_ff};
          `SHR_OFS_STATUS:  dat_o <= {27'h0, state_ff, homed_ff, ref_switch_in_i};
          `SHR_OFS_REFOFS:  dat_o <= ref_ofs_ff;
          `SHR_OFS_INTST:   dat_o <= {28'h0, int_st_ff};
          `SHR_OFS_INTEN:   dat_o <= {28'h0, int_en_ff};
          default:          dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== shr_defs.vh
// Purpose: Shared constants for the safe homing block
// Assumes: 32-bit classic Wishbone register bus, 10 MHz clock
// Notes:   Offsets are byte addresses, one aligned word each
`ifndef SHR_DEFS_VH
`define SHR_DEFS_VH

`define SHR_CLK_HZ      32'd10000000
`define SHR_CYC_PER_US  (`SHR_CLK_HZ / 32'd1000000)

`define SHR_OFS_CTRL    6'h00
`define SHR_OFS_HOME    6'h04
`define SHR_OFS_MAXSPD  6'h08
`define SHR_OFS_MONTIME 6'h0c
`define SHR_OFS_BLOCK   6'h10
`define SHR_OFS_STATUS  6'h14
`define SHR_OFS_REFOFS  6'h18
`define SHR_OFS_INTST   6'h1c
`define SHR_OFS_INTCLR  6'h20
`define SHR_OFS_INTEN   6'h24
`define SHR_OFS_CMD     6'h28

`define SHR_CTRL_MODE_LO 0
`define SHR_CTRL_MODE_HI 1
`define SHR_CTRL_EDGE    2
`define SHR_CTRL_DIR     3
`define SHR_CTRL_PULSE   4

`define SHR_MODE_DIRECT  2'h0
`define SHR_MODE_REFSW   2'h1

`define SHR_RST_CTRL     5'h00
`define SHR_RST_HOME     32'h00000000
`define SHR_RST_MAXSPD   32'h00000000
`define SHR_RST_MONTIME  32'h00000000
`define SHR_RST_BLOCK    7'h00

`define SHR_CMD_ACK      0

`define SHR_EV_HOMED     0
`define SHR_EV_FAULT     1
`define SHR_EV_FAILSAFE  2
`define SHR_EV_DISCARD   3
`define SHR_EV_W         4

`endif

// ===== shr_edge.v
// Purpose: Change detector for a group of synchronous level inputs
// Assumes: Inputs are already synchronous to clk_i
// Notes:   Rise and fall are valid in the cycle the new level is seen
`default_nettype none
module shr_edge #(
  parameter W = 1
) (
  // Clock and control
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  // Levels in
  input  wire [W-1:0] lvl_i,
  // Changes out
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] prev_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= {W{1'b0}};
    end else if (ce_i) begin
      prev_ff <= lvl_i;
    end
  end

  assign rise_o = lvl_i & ~prev_ff;
  assign fall_o = ~lvl_i & prev_ff;
endmodule
`default_nettype wire

// ===== shr_homing_props.sv
// Purpose: Port checker for shr_homing
// Assumes: ce_i is held high
// Notes:   Bound to every shr_homing
`default_nettype none
module shr_homing_props (
  // Clock
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Axis
  input wire logic        ref_switch_wired_i,
  input wire logic        no_func_error_out_o,
  input wire logic        torque_enable_o,
  input wire logic        fail_safe_o,
  input wire logic        homed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o && ce_i; endsequence
  sequence s_fault; $fell(no_func_error_out_o); endsequence
  property p_ack_resp; s_take |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
  property p_fs_set; !ref_switch_wired_i |-> ##[1:2] fail_safe_o; endproperty
  a_fs_set: assert property (p_fs_set) else $error("no fail safe");
  property p_fs_hold; fail_safe_o |=> fail_safe_o; endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fail safe left");
  property p_fs_torque; fail_safe_o |-> !torque_enable_o; endproperty
  a_fs_torque: assert property (p_fs_torque) else $error("torque in fail");
  property p_fault_torque; s_fault |-> !torque_enable_o; endproperty
  a_fault_torque: assert property (p_fault_torque) else $error("torque kept");
  property p_homed_clr; s_fault |-> ##[0:1] !homed_o; endproperty
  a_homed_clr: assert property (p_homed_clr) else $error("homed kept");
endmodule
bind shr_homing shr_homing_props u_shr_homing_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .ref_switch_wired_i(ref_switch_wired_i),
  .no_func_error_out_o(no_func_error_out_o), .torque_enable_o(torque_enable_o),
  .fail_safe_o(fail_safe_o), .homed_o(homed_o));
`default_nettype wire

// ===== shr_axis_model.sv
// Purpose: Moving axis with switch and revolution pulse
// Assumes: Bench sets step per cycle and may load position
// Notes:   Switch is a clean window, so it never chatters
`default_nettype none
module shr_axis_model #(
  parameter int REV   = 200,
  parameter int SW_LO = 1000,
  parameter int SW_HI = 1100
) (
  // Control
  input wire logic        clk_i,
  input wire logic        ld_i,
  input wire logic [31:0] ld_pos_i,
  input wire logic [31:0] step_i,
  // Axis
  output logic     [31:0] pos_o,
  output logic            switch_o,
  output logic            pulse_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pos_o = 32'h0;
  always @(posedge clk_i) begin
    if (ld_i) begin
      pos_o <= ld_pos_i;
    end else begin
      pos_o <= pos_o + step_i;
    end
  end
  // Width 100 is far above twice any standstill tolerance used
  assign switch_o = ($signed(pos_o) >= SW_LO) && ($signed(pos_o) < SW_HI);
  assign pulse_o = (pos_o % REV) == 0;
endmodule
`default_nettype wire

// ===== shr_homing_test.sv
// Purpose: Self-checking bench for shr_homing
// Assumes: Ten MHz clock, ce_i and sel_i tied on
// Notes:   Revolution shortened to 200 units
`default_nettype none
`include "shr_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module shr_homing_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        req = 1'b0, wired = 1'b1, ld = 1'b0;
  logic [5:0]  adr_i = 6'h00;
  logic [31:0] dat_i = 32'h0, ld_pos = 32'h0, step = 32'h0;
  wire  [31:0] dat_o, axis_pos_o, enc;
  wire         ack_o, nfe, torque, fs, homed_o, irq_o, sw, pulse;
  int          n_errors = 0, n_compared = 0;
  always #50 clk_i = ~clk_i;
  shr_homing #(.REV_UNITS(32'd200)) u_shr_homing (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .homing_request_in_i(req), .ref_switch_in_i(sw),
    .ref_switch_wired_i(wired), .ref_pulse_i(pulse), .enc_pos_i(enc),
    .no_func_error_out_o(nfe), .torque_enable_o(torque), .fail_safe_o(fs),
    .homed_o(homed_o), .axis_pos_o(axis_pos_o), .irq_o(irq_o));
  shr_axis_model u_shr_axis_model (.clk_i(clk_i), .ld_i(ld), .ld_pos_i(ld_pos),
    .step_i(step), .pos_o(enc), .switch_o(sw), .pulse_o(pulse));
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (i = 0; i < 8 && ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 8) begin
      n_errors++;
      tally_and_finish();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic near(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return ($signed(d) >= -6) && ($signed(d) <= 6);
  endfunction
  // One homing pass: load start, move, request, judge where it homed
  task automatic run(input logic [31:0] ctl, st, stp, loc, input logic h, input int lim);
    int i;
    wr(`SHR_OFS_CTRL, ctl);
    ld <= 1'b1;
    ld_pos <= st;
    step <= stp;
    pause(1);
    ld <= 1'b0;
    req <= 1'b1;
    pause(2);
    for (i = 0; i < lim && homed_o !== 1'b1; i++) @(posedge clk_i);
    step <= 32'h0;
    req <= 1'b0;
    pause(3);
    `CHK(homed_o, h)
    if (h) begin
      `CHK(near(enc, loc), 1'b1)
      `CHK(near(axis_pos_o, 32'h1234), 1'b1)
    end
  endtask
  task automatic t_defaults();
    logic [5:0]  ofs [5] = '{`SHR_OFS_CTRL, `SHR_OFS_HOME, `SHR_OFS_MAXSPD,
                             `SHR_OFS_MONTIME, `SHR_OFS_BLOCK};
    logic [31:0] q;
    foreach (ofs[k]) begin
      wb(1'b0, ofs[k], 32'h0, q);
      `CHK(q, 32'h0)
    end
    wb(1'b0, 6'h2c, 32'h0, q);
    `CHK(q, 32'h0)
  endtask
  // Step 1 is 1e7 units/s, step 3 is 3e7 against a 2e7 limit
  task automatic t_edges();
    wr(`SHR_OFS_HOME, 32'h1234);
    wr(`SHR_OFS_MAXSPD, 32'h01312d00);
    run(32'h01, 900, 1, 1000, 1'b1, 300);
    run(32'h05, 900, 1, 1100, 1'b1, 300);
    run(32'h09, 1200, -1, 999, 1'b1, 300);
    run(32'h0d, 1200, -1, 1099, 1'b1, 300);
  endtask
  // Half a turn lets the 1200 pulse through, a full turn blocks it
  task automatic t_pulse();
    wr(`SHR_OFS_BLOCK, 32'd50);
    run(32'h11, 900, 1, 1200, 1'b1, 400);
    wr(`SHR_OFS_BLOCK, 32'd100);
    run(32'h11, 900, 1, 1400, 1'b1, 600);
  endtask
  // Reversal, then overspeed, while searching for the pulse
  task automatic t_abort();
    logic [31:0] q;
    wr(`SHR_OFS_INTCLR, 32'hf);
    wr(`SHR_OFS_CTRL, 32'h11);
    ld <= 1'b1;
    ld_pos <= 32'd990;
    step <= 32'd1;
    pause(1);
    ld <= 1'b0;
    req <= 1'b1;
    pause(20);
    step <= 32'hffffffff;
    pause(10);
    wb(1'b0, `SHR_OFS_STATUS, 32'h0, q);
    `CHK(q[4:2], 3'h1)
    wb(1'b0, `SHR_OFS_INTST, 32'h0, q);
    `CHK(q[3], 1'b1)
    step <= 32'd1;
    pause(15);
    wb(1'b0, `SHR_OFS_STATUS, 32'h0, q);
    `CHK(q[4:2], 3'h2)
    step <= 32'd3;
    pause(4);
    `CHK(nfe, 1'b0)
    `CHK(torque, 1'b0)
    `CHK(homed_o, 1'b0)
    step <= 32'h0;
    req <= 1'b0;
    wr(`SHR_OFS_CMD, 32'h1);
    wr(`SHR_OFS_INTCLR, 32'hf);
    pause(3);
    `CHK(nfe, 1'b1)
  endtask
  task automatic t_overspeed();
    logic [31:0] q;
    wr(`SHR_OFS_MONTIME, 32'd5);
    run(32'h01, 960, 3, 0, 1'b0, 80);
    `CHK(nfe, 1'b0)
    `CHK(torque, 1'b0)
    wb(1'b0, `SHR_OFS_INTST, 32'h0, q);
    `CHK(q[3:1], 3'h5)
    wr(`SHR_OFS_INTEN, 32'h2);
    pause(3);
    `CHK(irq_o, 1'b1)
    wr(`SHR_OFS_INTEN, 32'h0);
    pause(3);
    `CHK(irq_o, 1'b0)
    wr(`SHR_OFS_INTEN, 32'h2);
    wr(`SHR_OFS_INTCLR, 32'h2);
    pause(3);
    `CHK(irq_o, 1'b0)
    `CHK(nfe, 1'b0)
    wr(`SHR_OFS_CMD, 32'h1);
    pause(3);
    `CHK(nfe, 1'b1)
    wr(`SHR_OFS_MONTIME, 32'd0);
  endtask
  // Fail safe must outlast a rewired switch
  task automatic t_fail_safe();
    wired <= 1'b0;
    pause(4);
    `CHK(fs, 1'b1)
    `CHK(torque, 1'b0)
    wired <= 1'b1;
    pause(4);
    `CHK(fs, 1'b1)
  endtask
  initial begin
    pause(20);
    rst_i <= 1'b0;
    pause(2);
    t_defaults();
    t_edges();
    t_pulse();
    t_abort();
    t_overspeed();
    t_fail_safe();
    tally_and_finish();
  end
endmodule
`default_nettype wire
